// File: design/sft_cfg.svh
// Offsets, field values and timing counts of the parameter table block
`ifndef SFT_CFG_SVH
`define SFT_CFG_SVH
// Register byte offsets
`define SFT_OFS_CMD        8'h00
`define SFT_OFS_DATA       8'h04
`define SFT_OFS_STAT       8'h08
`define SFT_OFS_FSTAT      8'h0C
`define SFT_OFS_ARRAY      8'h10
// Status fields
`define SFT_STAT_READY     0
`define SFT_STAT_REFUSED   1
// Reset and delivery values
`define SFT_PTR_RST        24'h000000
`define SFT_FLASH_STATUS   8'h00
`define SFT_ERASED_BYTE    8'hFF
`define SFT_RESERVED       8'hFF
// Command word layout
`define SFT_OP_READ_PARAM  8'h5A
// Power-up wait
`define SFT_PU_WAIT_US     100
`define SFT_MCLK_KHZ       40000
`define SFT_PU_WAIT_CYC    ((`SFT_PU_WAIT_US * `SFT_MCLK_KHZ + 999) / 1000)
// Header
`define SFT_SIG            32'h50444653
`define SFT_REV_MINOR      8'h00
`define SFT_REV_MAJOR      8'h01
`define SFT_HDR_COUNT      8'h00
`define SFT_PT_ID          8'h00
`define SFT_PT_LEN         8'h09
`define SFT_PT_PTR         24'h000030
// Parameter dwords
`define SFT_ERASE_GRAN     2'b01
`define SFT_OP_4K          8'h20
`define SFT_DENSITY        32'h003FFFFF
`define SFT_DUMMY_0        5'b00000
`define SFT_DUMMY_4        5'b00100
`define SFT_DUMMY_8        5'b01000
`define SFT_MODE_0         3'b000
`define SFT_MODE_8         3'b010
`define SFT_OP_144         8'hEB
`define SFT_OP_114         8'h6B
`define SFT_OP_112         8'h3B
`define SFT_OP_122         8'hBB
`define SFT_OP_222         8'hFF
`define SFT_OP_444         8'hEB
`define SFT_ER1_SIZE       8'h0C
`define SFT_ER1_OP         8'h20
`define SFT_ER2_SIZE       8'h0F
`define SFT_ER2_OP         8'h52
`define SFT_ER3_SIZE       8'h10
`define SFT_ER3_OP         8'hD8
`define SFT_ER4_SIZE       8'h00
`define SFT_ER4_OP         8'hFF
`endif

// File: design/sft_pkg.sv
// Types shared by the parameter table block
package sft_pkg;
  typedef logic [23:0] sft_addr_type;
  typedef enum logic [5:0] {
    SFT_SEL_CMD   = 6'b000001,
    SFT_SEL_DATA  = 6'b000010,
    SFT_SEL_STAT  = 6'b000100,
    SFT_SEL_FSTAT = 6'b001000,
    SFT_SEL_ARRAY = 6'b010000,
    SFT_SEL_NONE  = 6'b100000
  } sft_sel_type;
endpackage

// File: design/sft_parameter_table.sv
// Discoverable-parameter table behind a classic Wishbone slave
//
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "sft_cfg.svh"

module sft_parameter_table #(
  parameter int PU_CYC = `SFT_PU_WAIT_CYC
) (
  // Clock, reset, enable
  input  wire  logic        mclk,
  input  wire  logic        reset,
  input  wire  logic        ce,
  // Wishbone slave
  input  wire  logic        wb_cyc_i,
  input  wire  logic        wb_stb_i,
  input  wire  logic        wb_we_i,
  input  wire  logic [7:0]  wb_adr_i,
  input  wire  logic [3:0]  wb_sel_i,
  input  wire  logic [31:0] wb_dat_i,
  output       logic [31:0] wb_dat_o,
  output       logic        wb_ack_o,
  // Status
  output       logic        pu_ready,
  output       sft_pkg::sft_addr_type table_ptr
);
  import sft_pkg::*;

  if (PU_CYC < 1 || PU_CYC > 4095)
  begin : g_chk
    $error("PU_CYC must lie between 1 and 4095");
  end

  localparam logic [11:0] PU_LAST = 12'(PU_CYC - 1);

  function automatic logic [7:0] sft_byte(input sft_addr_type a);
    logic [7:0] b;
    b = `SFT_RESERVED;
    case (a)
      24'h000000: b = 8'(`SFT_SIG);
      24'h000001: b = 8'(`SFT_SIG >> 8);
      24'h000002: b = 8'(`SFT_SIG >> 16);
      24'h000003: b = 8'(`SFT_SIG >> 24);
      24'h000004: b = `SFT_REV_MINOR;
      24'h000005: b = `SFT_REV_MAJOR;
      24'h000006: b = `SFT_HDR_COUNT;
      24'h000008: b = `SFT_PT_ID;
      24'h000009: b = `SFT_REV_MINOR;
      24'h00000A: b = `SFT_REV_MAJOR;
      24'h00000B: b = `SFT_PT_LEN;
      24'h00000C: b = 8'(`SFT_PT_PTR);
      24'h00000D: b = 8'(`SFT_PT_PTR >> 8);
      24'h00000E: b = 8'(`SFT_PT_PTR >> 16);
      24'h000030: b = {3'b111, 2'b00, 1'b1, `SFT_ERASE_GRAN};
      24'h000031: b = `SFT_OP_4K;
      // Top bit reserved, then 1-1-4, 1-4-4, 1-2-2, no DTR, 3-byte, 1-1-2
      24'h000032: b = {1'b1, 3'b111, 1'b0, 2'b00, 1'b1};
      24'h000034: b = 8'(`SFT_DENSITY);
      24'h000035: b = 8'(`SFT_DENSITY >> 8);
      24'h000036: b = 8'(`SFT_DENSITY >> 16);
      24'h000037: b = 8'(`SFT_DENSITY >> 24);
      24'h000038: b = {`SFT_MODE_8, `SFT_DUMMY_4};
      24'h000039: b = `SFT_OP_144;
      24'h00003A: b = {`SFT_MODE_0, `SFT_DUMMY_8};
      24'h00003B: b = `SFT_OP_114;
      24'h00003C: b = {`SFT_MODE_0, `SFT_DUMMY_8};
      24'h00003D: b = `SFT_OP_112;
      24'h00003E: b = {`SFT_MODE_0, `SFT_DUMMY_4};
      24'h00003F: b = `SFT_OP_122;
      24'h000040: b = {3'b111, 1'b1, 3'b111, 1'b0};
      24'h000046: b = {`SFT_MODE_0, `SFT_DUMMY_0};
      24'h000047: b = `SFT_OP_222;
      24'h00004A: b = {`SFT_MODE_8, `SFT_DUMMY_4};
      24'h00004B: b = `SFT_OP_444;
      24'h00004C: b = `SFT_ER1_SIZE;
      24'h00004D: b = `SFT_ER1_OP;
      24'h00004E: b = `SFT_ER2_SIZE;
      24'h00004F: b = `SFT_ER2_OP;
      24'h000050: b = `SFT_ER3_SIZE;
      24'h000051: b = `SFT_ER3_OP;
      24'h000052: b = `SFT_ER4_SIZE;
      24'h000053: b = `SFT_ER4_OP;
      default:    b = `SFT_RESERVED;
    endcase
    return b;
  endfunction

  sft_sel_type  sel;
  logic         req;
  logic         rd_data;
  logic         wr_cmd;
  logic         cmd_ok;
  logic         refused;
  logic [11:0]  pu_cnt;
  logic [31:0]  next_dat;

  // Classic cycle: one request per ack, ack drops the cycle after
  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign rd_data = req & ~wb_we_i & (sel == SFT_SEL_DATA);
  // Full-word write only, so opcode and address always arrive together
  assign wr_cmd  = req & wb_we_i & (sel == SFT_SEL_CMD) & (&wb_sel_i);
  assign cmd_ok  = wr_cmd & pu_ready & (wb_dat_i[31:24] == `SFT_OP_READ_PARAM);

  always_comb
  begin
    case (wb_adr_i)
      `SFT_OFS_CMD:   sel = SFT_SEL_CMD;
      `SFT_OFS_DATA:  sel = SFT_SEL_DATA;
      `SFT_OFS_STAT:  sel = SFT_SEL_STAT;
      `SFT_OFS_FSTAT: sel = SFT_SEL_FSTAT;
      `SFT_OFS_ARRAY: sel = SFT_SEL_ARRAY;
      default:        sel = SFT_SEL_NONE;
    endcase
  end

  // Power-up wait before any command is served
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      pu_cnt <= 12'h000;
    else if (ce && !pu_ready)
      pu_cnt <= pu_cnt + 12'h001;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      pu_ready <= 1'b0;
    else if (ce && pu_cnt == PU_LAST)
      pu_ready <= 1'b1;
  end

  // Table pointer; wraps to zero past the top
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      table_ptr <= `SFT_PTR_RST;
    else if (ce)
    begin
      if (cmd_ok)
        table_ptr <= wb_dat_i[23:0];
      else if (rd_data && pu_ready)
        table_ptr <= table_ptr + 24'h000001;
    end
  end

  // Refused command or early read; a good command clears it
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      refused <= 1'b0;
    else if (ce)
    begin
      if ((wr_cmd && !cmd_ok) || (rd_data && !pu_ready))
        refused <= 1'b1;
      else if (cmd_ok)
        refused <= 1'b0;
    end
  end

  always_comb
  begin
    next_dat = 32'h00000000;
    case (sel)
      SFT_SEL_CMD:   next_dat = {8'h00, table_ptr};
      // Early reads see erased data and leave the pointer alone
      SFT_SEL_DATA:  next_dat = {24'h000000,
                                 pu_ready ? sft_byte(table_ptr) : `SFT_ERASED_BYTE};
      SFT_SEL_STAT:
      begin
        next_dat[`SFT_STAT_READY]   = pu_ready;
        next_dat[`SFT_STAT_REFUSED] = refused;
      end
      SFT_SEL_FSTAT: next_dat = {24'h000000, `SFT_FLASH_STATUS};
      SFT_SEL_ARRAY: next_dat = {24'h000000, `SFT_ERASED_BYTE};
      default:       next_dat = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      wb_ack_o <= 1'b0;
    else if (ce)
      wb_ack_o <= req;
  end

  // Writes never reach the table; a write loads zero, a read loads the selected register
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      wb_dat_o <= 32'h00000000;
    else if (ce && req)
      wb_dat_o <= wb_we_i ? 32'h00000000 : next_dat;
  end

  // Assertion helpers: what the acked access was
  sft_sel_type  last_sel;
  logic         last_rd;
  logic         last_wr;
  logic         last_ready;
  sft_addr_type tbl_addr;
  sft_addr_type prev_ptr;
  logic         tbl_hit;

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      last_sel   <= SFT_SEL_NONE;
      last_rd    <= 1'b0;
      last_wr    <= 1'b0;
      last_ready <= 1'b0;
      tbl_addr   <= 24'h000000;
      prev_ptr   <= 24'h000000;
    end
    else if (ce)
    begin
      last_sel   <= sel;
      last_rd    <= req & ~wb_we_i;
      last_wr    <= req & wb_we_i;
      last_ready <= pu_ready;
      tbl_addr   <= table_ptr;
      prev_ptr   <= table_ptr;
    end
  end

  assign tbl_hit = wb_ack_o & last_rd & last_ready & (last_sel == SFT_SEL_DATA);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  property p_dual_out;
    tbl_hit && tbl_addr == 24'h000032 |-> wb_dat_o[0];
  endproperty
  a_dual_out: assert property (p_dual_out)
    else $error("dual output read not advertised");

  property p_addr_bytes;
    tbl_hit && tbl_addr == 24'h000032 |-> wb_dat_o[2:1] == 2'b00;
  endproperty
  a_addr_bytes: assert property (p_addr_bytes)
    else $error("address byte field not 00b");

  property p_no_dtr;
    tbl_hit && tbl_addr == 24'h000032 |-> !wb_dat_o[3];
  endproperty
  a_no_dtr: assert property (p_no_dtr)
    else $error("double rate bit set");

  property p_multi_io;
    tbl_hit && tbl_addr == 24'h000032 |-> wb_dat_o[6:4] == 3'b111;
  endproperty
  a_multi_io: assert property (p_multi_io)
    else $error("multi-line read bits not all set");

  property p_density;
    tbl_hit && tbl_addr[23:2] == 22'h00000D
      |-> wb_dat_o[7:0] == 8'(32'h003FFFFF >> {tbl_addr[1:0], 3'b000});
  endproperty
  a_density: assert property (p_density)
    else $error("density word wrong");

  property p_read_144;
    tbl_hit |-> (tbl_addr == 24'h000038 ? wb_dat_o[7:0] == 8'h44 :
                 tbl_addr == 24'h000039 ? wb_dat_o[7:0] == 8'hEB : 1'b1);
  endproperty
  a_read_144: assert property (p_read_144)
    else $error("1-4-4 read fields wrong");

  property p_read_114;
    tbl_hit |-> (tbl_addr == 24'h00003A ? wb_dat_o[7:0] == 8'h08 :
                 tbl_addr == 24'h00003B ? wb_dat_o[7:0] == 8'h6B : 1'b1);
  endproperty
  a_read_114: assert property (p_read_114)
    else $error("1-1-4 read fields wrong");

  property p_read_112;
    tbl_hit |-> (tbl_addr == 24'h00003C ? wb_dat_o[7:0] == 8'h08 :
                 tbl_addr == 24'h00003D ? wb_dat_o[7:0] == 8'h3B : 1'b1);
  endproperty
  a_read_112: assert property (p_read_112)
    else $error("1-1-2 read fields wrong");

  property p_read_122;
    tbl_hit |-> (tbl_addr == 24'h00003E ? wb_dat_o[7:0] == 8'h04 :
                 tbl_addr == 24'h00003F ? wb_dat_o[7:0] == 8'hBB : 1'b1);
  endproperty
  a_read_122: assert property (p_read_122)
    else $error("1-2-2 read fields wrong");

  property p_no_222;
    tbl_hit |-> (tbl_addr == 24'h000040 ? !wb_dat_o[0] :
                 tbl_addr == 24'h000046 ? wb_dat_o[7:0] == 8'h00 :
                 tbl_addr == 24'h000047 ? wb_dat_o[7:0] == 8'hFF : 1'b1);
  endproperty
  a_no_222: assert property (p_no_222)
    else $error("2-2-2 read not shown unsupported");

  property p_quad_all;
    tbl_hit && tbl_addr == 24'h000040 |-> wb_dat_o[4];
  endproperty
  a_quad_all: assert property (p_quad_all)
    else $error("all-quad read not advertised");

  property p_read_444;
    tbl_hit |-> (tbl_addr == 24'h00004A ? wb_dat_o[7:0] == 8'h44 :
                 tbl_addr == 24'h00004B ? wb_dat_o[7:0] == 8'hEB : 1'b1);
  endproperty
  a_read_444: assert property (p_read_444)
    else $error("all-quad read fields wrong");

  property p_reserved;
    tbl_hit && (tbl_addr inside {[24'h000041:24'h000045], 24'h000048, 24'h000049,
                                 24'h000033, 24'h000007, 24'h00000F})
      |-> wb_dat_o[7:0] == 8'hFF;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved byte not all ones");

  property p_erase1;
    tbl_hit |-> (tbl_addr == 24'h00004C ? wb_dat_o[7:0] == 8'h0C :
                 tbl_addr == 24'h00004D ? wb_dat_o[7:0] == 8'h20 : 1'b1);
  endproperty
  a_erase1: assert property (p_erase1)
    else $error("erase type one wrong");

  property p_erase2;
    tbl_hit |-> (tbl_addr == 24'h00004E ? wb_dat_o[7:0] == 8'h0F :
                 tbl_addr == 24'h00004F ? wb_dat_o[7:0] == 8'h52 : 1'b1);
  endproperty
  a_erase2: assert property (p_erase2)
    else $error("erase type two wrong");

  property p_erase3;
    tbl_hit |-> (tbl_addr == 24'h000050 ? wb_dat_o[7:0] == 8'h10 :
                 tbl_addr == 24'h000051 ? wb_dat_o[7:0] == 8'hD8 : 1'b1);
  endproperty
  a_erase3: assert property (p_erase3)
    else $error("erase type three wrong");

  property p_erase4;
    tbl_hit |-> (tbl_addr == 24'h000052 ? wb_dat_o[7:0] == 8'h00 :
                 tbl_addr == 24'h000053 ? wb_dat_o[7:0] == 8'hFF : 1'b1);
  endproperty
  a_erase4: assert property (p_erase4)
    else $error("erase type four not absent");

  property p_early_read;
    wb_ack_o && last_rd && !last_ready && last_sel == SFT_SEL_DATA
      |-> wb_dat_o == 32'h000000FF && table_ptr == prev_ptr ##1 !wb_ack_o;
  endproperty
  a_early_read: assert property (p_early_read)
    else $error("read served before power-up wait");

  property p_shipped;
    wb_ack_o && last_rd && last_sel inside {SFT_SEL_FSTAT, SFT_SEL_ARRAY}
      |-> wb_dat_o == (last_sel == SFT_SEL_FSTAT ? 32'h00000000 : 32'h000000FF);
  endproperty
  a_shipped: assert property (p_shipped)
    else $error("delivery state wrong");

  property p_incr;
    tbl_hit |-> table_ptr == tbl_addr + 24'h000001;
  endproperty
  a_incr: assert property (p_incr)
    else $error("pointer did not advance by one");

  property p_header;
    tbl_hit |-> (tbl_addr == 24'h000000 ? wb_dat_o[7:0] == 8'h53 :
                 tbl_addr == 24'h000003 ? wb_dat_o[7:0] == 8'h50 :
                 tbl_addr == 24'h00000C ? wb_dat_o[7:0] == 8'h30 : 1'b1);
  endproperty
  a_header: assert property (p_header)
    else $error("header signature or pointer wrong");

  property p_const;
    wb_ack_o && last_wr && last_sel != SFT_SEL_CMD |-> table_ptr == prev_ptr;
  endproperty
  a_const: assert property (p_const)
    else $error("write to a read-only register had an effect");

  property p_beyond;
    tbl_hit && tbl_addr > 24'h000053 |-> wb_dat_o[7:0] == 8'hFF;
  endproperty
  a_beyond: assert property (p_beyond)
    else $error("byte past table not FFh");

  c_cap_read: cover property (tbl_hit && tbl_addr == 24'h000032);
  c_cmd_ok: cover property (cmd_ok);
  c_refused: cover property (wr_cmd && !cmd_ok);
  c_wrap: cover property (tbl_hit && tbl_addr == 24'hFFFFFF);

endmodule // sft_parameter_table

// File: testbench/sft_host_model.sv
// Wishbone master standing in for the host controller that reads the table
`timescale 1ns/100ps

module sft_host_model (
  // Clock and reset
  input  wire  logic        mclk,
  input  wire  logic        reset,
  // Request from the bench
  input  wire  logic        req,
  input  wire  logic        req_we,
  input  wire  logic [7:0]  req_adr,
  input  wire  logic [3:0]  req_sel,
  input  wire  logic [31:0] req_dat,
  output       logic        done,
  output       logic [31:0] rdata,
  // Wishbone master
  output       logic        wb_cyc_o,
  output       logic        wb_stb_o,
  output       logic        wb_we_o,
  output       logic [7:0]  wb_adr_o,
  output       logic [3:0]  wb_sel_o,
  output       logic [31:0] wb_dat_o,
  input  wire  logic [31:0] wb_dat_i,
  input  wire  logic        wb_ack_i
);
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      wb_cyc_o <= 1'b0;
      wb_stb_o <= 1'b0;
      wb_we_o  <= 1'b0;
      wb_adr_o <= 8'h00;
      wb_sel_o <= 4'h0;
      wb_dat_o <= 32'h00000000;
      done     <= 1'b0;
      rdata    <= 32'h00000000;
    end
    else
    begin
      done <= 1'b0;
      // Done guard stops a held request from being issued twice
      if (!wb_cyc_o && req && !done)
      begin
        wb_cyc_o <= 1'b1;
        wb_stb_o <= 1'b1;
        wb_we_o  <= req_we;
        wb_adr_o <= req_adr;
        wb_sel_o <= req_sel;
        wb_dat_o <= req_dat;
      end
      else if (wb_cyc_o && wb_ack_i)
      begin
        wb_cyc_o <= 1'b0;
        wb_stb_o <= 1'b0;
        rdata    <= wb_dat_i;
        done     <= 1'b1;
        // Released we, address and data lines show no stale value; sel keeps its value
        wb_we_o  <= ~wb_we_o;
        wb_adr_o <= ~wb_adr_o;
        wb_dat_o <= ~wb_dat_o;
      end
    end
  end
endmodule // sft_host_model

// File: testbench/sft_parameter_table_tb.sv
// Self-checking bench for the parameter table block
`timescale 1ns/100ps

module sft_parameter_table_tb;
  import sft_pkg::*;
  localparam int PU_CYC = 40;
  localparam int MAX_CYC = 20000;
  localparam logic [7:0] HDR [0:15] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h00, 8'hFF,
    8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF};
  localparam logic [7:0] PRM [0:35] = '{8'hE5, 8'h20, 8'hF1, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h00,
    8'h44, 8'hEB, 8'h08, 8'h6B, 8'h08, 8'h3B, 8'h04, 8'hBB, 8'hFE, 8'hFF, 8'hFF, 8'hFF,
    8'hFF, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h44, 8'hEB, 8'h0C, 8'h20, 8'h0F, 8'h52,
    8'h10, 8'hD8, 8'h00, 8'hFF};
  logic         mclk = 1'b0;
  logic         reset = 1'b1;
  logic         req = 1'b0;
  logic         req_we = 1'b0;
  logic [7:0]   req_adr = 8'h00;
  logic [3:0]   req_sel = 4'h0;
  logic [31:0]  req_dat = 32'h00000000;
  logic         done;
  logic [31:0]  rdata;
  logic         wb_cyc, wb_stb, wb_we, wb_ack, pu_ready;
  logic [7:0]   wb_adr;
  logic [3:0]   wb_sel;
  logic [31:0]  wb_dat_w, wb_dat_r, rd;
  logic [31:0]  rnd = 32'h00000000;
  logic         ce = 1'b1;
  sft_addr_type table_ptr;
  int           bad_count = 0;
  int           samples_checked = 0;
  int           cycles = 0;
  logic [23:0]  mptr = 24'h000000;
  logic         mpu = 1'b0;
  logic         mref = 1'b0;
  logic [31:0]  seed = 32'h00003A6F;

  always #12.5 mclk = ~mclk;

  sft_host_model i_host (.mclk(mclk), .reset(reset), .req(req), .req_we(req_we),
    .req_adr(req_adr), .req_sel(req_sel), .req_dat(req_dat), .done(done), .rdata(rdata),
    .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr),
    .wb_sel_o(wb_sel), .wb_dat_o(wb_dat_w), .wb_dat_i(wb_dat_r), .wb_ack_i(wb_ack));

  // Clock enable dropped once, during the second power-up wait
  sft_parameter_table #(.PU_CYC(PU_CYC)) i_dut (.mclk(mclk), .reset(reset), .ce(ce),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .pu_ready(pu_ready), .table_ptr(table_ptr));

  function automatic logic [7:0] exp_byte(input logic [23:0] a);
    if (a < 24'h000010)
      return HDR[a[3:0]];
    if (a >= 24'h000030 && a < 24'h000054)
      return PRM[a[5:0] - 6'h30];
    return 8'hFF;
  endfunction

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic complete_run();
    $display("checked %0d values, %0d wrong", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                     input logic [31:0] dat);
    @(posedge mclk);
    req     <= 1'b1;
    req_we  <= we;
    req_adr <= adr;
    req_sel <= sel;
    req_dat <= dat;
    do
    begin
      @(posedge mclk);
      #1;
    end
    while (done !== 1'b1);
    rd = rdata;
    @(posedge mclk);
    req <= 1'b0;
  endtask

  task automatic rd_byte();
    bus(1'b0, 8'h04, 4'hF, 32'h00000000);
    check("table byte", rd, {24'h000000, mpu ? exp_byte(mptr) : 8'hFF});
    if (mpu)
      mptr = mptr + 24'h000001;
    else
      mref = 1'b1;
    check("pointer", {8'h00, table_ptr}, {8'h00, mptr});
  endtask

  task automatic cmd(input logic [31:0] w, input logic [3:0] sel);
    bus(1'b1, 8'h00, sel, w);
    if (mpu && w[31:24] == 8'h5A && sel == 4'hF)
    begin
      mptr = w[23:0];
      mref = 1'b0;
    end
    // Partial-width command writes are ignored without a mark
    else if (sel == 4'hF)
      mref = 1'b1;
    check("pointer after command", {8'h00, table_ptr}, {8'h00, mptr});
  endtask

  task automatic rd_reg(input logic [7:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 4'hF, 32'h00000000);
    check("register", rd, exp);
  endtask

  task automatic wait_ready();
    repeat (2 * PU_CYC)
    begin
      @(posedge mclk);
      #1;
      if (pu_ready === 1'b1)
        break;
    end
    check("ready", {31'h0, pu_ready}, 32'h00000001);
    mpu = 1'b1;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == MAX_CYC)
    begin
      bad_count++;
      complete_run();
    end
  end

  initial
  begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    // Early data reads and commands are refused until the power-up wait ends; the status read is served
    @(posedge mclk);
    #1;
    check("early ready", {31'h0, pu_ready}, 32'h00000000);
    rd_byte();
    cmd(32'h5A000030, 4'hF);
    rd_reg(8'h08, {30'h0, mref, 1'b0});
    wait_ready();
    cmd(32'h5B000010, 4'hF);
    cmd(32'h5A000010, 4'h7);
    rd_reg(8'h08, {30'h0, mref, mpu});
    cmd(32'h5A000000, 4'hF);
    rd_reg(8'h08, {30'h0, mref, mpu});
    $display("test 1 done");
    // Whole table plus a stretch of unused bytes
    repeat (96) rd_byte();
    $display("test 2 done");
    // Random starts and ignored writes to read-only places
    for (int i = 0; i < 8; i++)
    begin
      rnd = xs();
      bus(1'b1, 8'h04 << (i % 4), 4'hF, xs());
      cmd({8'h5A, i[0] ? rnd[23:0] : {16'h0000, 2'b01, rnd[5:0]}}, 4'hF);
      repeat (6) rd_byte();
    end
    cmd(32'h5A00004C, 4'hF);
    repeat (8) rd_byte();
    $display("test 3 done");
    // Pointer wrap and the other registers
    cmd(32'h5AFFFFFF, 4'hF);
    repeat (2) rd_byte();
    rd_reg(8'h00, {8'h00, mptr});
    rd_reg(8'h0C, 32'h00000000);
    rd_reg(8'h10, 32'h000000FF);
    rd_reg(8'h14, 32'h00000000);
    $display("test 4 done");
    // Reset in mid-run restarts the wait and clears the pointer
    @(posedge mclk);
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    check("reset pointer", {8'h00, table_ptr}, 32'h00000000);
    check("reset ready", {31'h0, pu_ready}, 32'h00000000);
    @(posedge mclk);
    reset <= 1'b0;
    ce    <= 1'b0;
    mpu = 1'b0;
    mptr = 24'h000000;
    mref = 1'b0;
    // Enable low must hold the power-up count still
    repeat (2 * PU_CYC) @(posedge mclk);
    #1;
    check("frozen ready", {31'h0, pu_ready}, 32'h00000000);
    check("frozen pointer", {8'h00, table_ptr}, 32'h00000000);
    @(posedge mclk);
    ce <= 1'b1;
    wait_ready();
    cmd(32'h5A000032, 4'hF);
    rd_byte();
    $display("test 5 done");
    complete_run();
  end
endmodule // sft_parameter_table_tb
